// >>> hdl/lwr_code_mem.sv
// Purpose: Four-byte store for the wake-up code bytes, usable as plain RAM.
// Assumes: One write port and one registered read port on the system clock.
// Notes: All entries are also exposed flat for the frame matcher.
`timescale 1ns/100ps
module lwr_code_mem
   import lwr_pkg::*;
#(
   parameter int DEPTH = 4,
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Write port.
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port.
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_q,
   output logic [DEPTH*WIDTH-1:0] contents
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];

   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_entry
         always_comb begin
            next_mem[g] = (wr_en && wr_addr == g) ? wr_data : mem[g];
         end
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               mem[g] <= '0;
            end else begin
               mem[g] <= next_mem[g];
            end
         end
         assign contents[g*WIDTH +: WIDTH] = mem[g];
      end
   endgenerate

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_q <= '0;
      end else begin
         rd_q <= mem[rd_addr];
      end
   end

endmodule : lwr_code_mem

// >>> hdl/lwr_wakeup_ctrl.sv
// Purpose: Control, sampling sequencer and status flags of the low-frequency wake-up receiver.
// Assumes: 100 MHz clock; detector and decoder signals arrive asynchronously from the front end.
// Notes: Time bases are one-cycle enables from dividers of the system clock.
//
// Function
// - Carrier detect mode ignores the wake-up code bytes completely.
// - The four wake-up code bytes are ordinary read/write storage.
// - The received byte register is read-only; writes do nothing.
// - Mode field bits 7:6 equal to 01 selects carrier detect operation.
// - Mode bit 5 picks minimum carrier length, 88 or 176 microseconds.
// - Mode bit 4 picks sample window length, 200 or 2120 microseconds.
// - Mode bits 3:0 pick the sampling interval; code 0101 means 32 ms.
// - With interrupt enable set, a valid carrier raises the wake interrupt.
// - Config bit 4 sets off-time between samples, one or two periods.
// - The receiver is active in sampling windows only while enable is 1.
// - Config bit 1 selects detector sensitivity, driven to the front end.
// - Flag register bit 5 reports carrier detected; software watches it.
// - Writing 1 to flag bit 4 clears the carrier flag; 0 does nothing.
// - With ignore bit 0 clear, the sampled detector output is used.
// - Config bit 7 and flag bits 7, 3, 2, 1 are read-only status.
// - Manchester mode accepts sync, identifier, data; only data reaches software.
// - Carrier flag sets when carrier lasts past the selected minimum length.
// - With ignore bit set, detector output is forced low during windows.
// - Writing 1 to data ack clears data ready and both match flags.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module lwr_wakeup_ctrl
   import lwr_pkg::*;
#(
   parameter int LFO_DIV = LFO_CYCLES,
   parameter int MFO_DIV = MFO_CYCLES
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Register port.
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Analogue front end.
   input wire logic detector_out,
   input wire logic dec_bit,
   input wire logic dec_bit_strobe,
   input wire logic dec_violation,
   output logic receiver_active,
   output logic high_sensitivity,
   // Wake request to the CPU.
   output logic lf_wake_irq
);

   lwr_mode_t mode, next_mode;
   lwr_cfg_t cfg, next_cfg;
   logic [7:0] flags, next_flags;
   logic [7:0] rx_byte, next_rx_byte;
   logic [7:0] reg_q, next_reg_q;
   logic mem_sel, next_mem_sel;
   logic irq_q, rx_on_q, sens_q;
   logic [31:0] codes;
   logic [7:0] mem_q;

   // Two-flop synchronisers for the front-end signals.
   logic [3:0] sync_meta, sync_q;
   logic strobe_d;
   logic det_s, bit_s, strobe_s, viol_s, det_eff, bit_evt;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_meta <= '0;
         sync_q <= '0;
         strobe_d <= 1'b0;
      end else begin
         sync_meta <= {dec_violation, dec_bit_strobe, dec_bit, detector_out};
         sync_q <= sync_meta;
         strobe_d <= sync_q[2];
      end
   end
   assign det_s = sync_q[0];
   assign bit_s = sync_q[1];
   assign strobe_s = sync_q[2];
   assign viol_s = sync_q[3];
   assign bit_evt = strobe_s & ~strobe_d;

   // Time-base dividers.
   logic [16:0] lfo_div, next_lfo_div;
   logic [9:0] mfo_div, next_mfo_div;
   logic lfo_tick, mfo_tick;
   always_comb begin
      lfo_tick = (lfo_div == 17'(LFO_DIV - 1));
      mfo_tick = (mfo_div == 10'(MFO_DIV - 1));
      next_lfo_div = lfo_tick ? '0 : lfo_div + 17'h1;
      next_mfo_div = mfo_tick ? '0 : mfo_div + 10'h1;
   end

   // Sampling sequencer.
   lwr_seq_t seq, next_seq;
   logic [16:0] per_cnt, next_per_cnt, per_target;
   logic [8:0] win_cnt, next_win_cnt, win_ticks;
   logic [4:0] car_cnt, next_car_cnt, car_ticks;
   logic mode_ok, carrier_mode, manch_mode, set_carrier;
   always_comb begin
      carrier_mode = (mode.receive_mode_sel == MODE_CARRIER);
      manch_mode = (mode.receive_mode_sel == MODE_MANCHESTER);
      mode_ok = carrier_mode | manch_mode;
      per_target = (17'h1 << mode.sample_interval_sel) << cfg.off_time_sel;
      win_ticks = mode.sample_window_length ? WIN_LONG_TICKS : WIN_SHORT_TICKS;
      car_ticks = mode.min_carrier_length_sel ? CARRIER_LONG_TICKS : CARRIER_SHORT_TICKS;
      // The ignore bit blanks the detector for the whole window.
      det_eff = det_s & ~flags[FB_IGNORE];
      next_seq = seq;
      next_per_cnt = per_cnt;
      next_win_cnt = win_cnt;
      next_car_cnt = car_cnt;
      set_carrier = 1'b0;
      case (seq)
         SEQ_IDLE: begin
            next_per_cnt = '0;
            if (cfg.receiver_enable && mode_ok) begin
               next_seq = SEQ_WAIT;
            end
         end
         SEQ_WAIT: begin
            if (lfo_tick) begin
               if (per_cnt + 17'h1 >= per_target) begin
                  next_seq = SEQ_WIN;
                  next_win_cnt = '0;
                  next_car_cnt = '0;
               end else begin
                  next_per_cnt = per_cnt + 17'h1;
               end
            end
         end
         SEQ_WIN: begin
            if (mfo_tick) begin
               if (carrier_mode && det_eff) begin
                  if (car_cnt == car_ticks - 5'h1) begin
                     set_carrier = 1'b1;
                  end
                  if (car_cnt != 5'h1f) begin
                     next_car_cnt = car_cnt + 5'h1;
                  end
               end else begin
                  next_car_cnt = '0;
               end
               if (win_cnt == win_ticks - 9'h1) begin
                  next_seq = SEQ_WAIT;
                  next_per_cnt = '0;
               end else begin
                  next_win_cnt = win_cnt + 9'h1;
               end
            end
         end
         default: next_seq = SEQ_IDLE;
      endcase
      // Dropping the enable stops sampling at once, whatever the phase.
      if (!cfg.receiver_enable || !mode_ok) begin
         next_seq = SEQ_IDLE;
      end
   end

   // Manchester frame receiver: sync character, identifier, then data bytes.
   lwr_frame_t frame, next_frame;
   logic [15:0] shift, next_shift;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic set_match_a, set_match_b, set_data, set_viol;
   logic [15:0] code_a, code_b;
   logic [4:0] id_len;
   always_comb begin
      code_a = cfg.wake_code_width_sel ? codes[15:0] : {8'h00, codes[7:0]};
      code_b = cfg.wake_code_width_sel ? codes[31:16] : {8'h00, codes[23:16]};
      id_len = cfg.wake_code_width_sel ? 5'd16 : 5'd8;
      next_frame = frame;
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_rx_byte = rx_byte;
      set_match_a = 1'b0;
      set_match_b = 1'b0;
      set_data = 1'b0;
      set_viol = 1'b0;
      // The matcher runs only in Manchester mode, so code bytes never touch carrier detection.
      if (seq != SEQ_WIN || !manch_mode) begin
         next_frame = FR_HUNT;
         next_bit_cnt = '0;
      end else if (viol_s && frame != FR_HUNT) begin
         set_viol = 1'b1;
         next_frame = FR_HUNT;
         next_bit_cnt = '0;
      end else if (bit_evt) begin
         next_shift = {shift[14:0], bit_s};
         next_bit_cnt = bit_cnt + 5'h1;
         case (frame)
            FR_HUNT: begin
               if (next_shift[7:0] == SYNC_CHAR) begin
                  next_frame = FR_ID;
                  next_bit_cnt = '0;
               end
            end
            FR_ID: begin
               if (next_bit_cnt == id_len) begin
                  next_bit_cnt = '0;
                  next_frame = FR_HUNT;
                  if ((next_shift & ~(16'hffff << id_len)) == code_a) begin
                     set_match_a = 1'b1;
                     next_frame = FR_DATA;
                  end
                  if ((next_shift & ~(16'hffff << id_len)) == code_b) begin
                     set_match_b = 1'b1;
                     next_frame = FR_DATA;
                  end
               end
            end
            FR_DATA: begin
               if (next_bit_cnt == 5'd8) begin
                  next_bit_cnt = '0;
                  next_rx_byte = next_shift[7:0];
                  set_data = 1'b1;
               end
            end
            default: next_frame = FR_HUNT;
         endcase
      end
   end

   // Register writes and status flags; a hardware set wins over a clear.
   logic wr_mode, wr_cfg, wr_flag, wr_code, clr_data, clr_car;
   always_comb begin
      wr_mode = reg_wr && reg_addr == OFF_MODE;
      wr_cfg = reg_wr && reg_addr == OFF_CFG;
      wr_flag = reg_wr && reg_addr == OFF_FLAG;
      wr_code = reg_wr && reg_addr >= OFF_CODE_A0 && reg_addr <= OFF_CODE_B1;
      clr_data = wr_flag && reg_wdata[FB_DATA_ACK];
      clr_car = wr_flag && reg_wdata[FB_CARRIER_ACK];
      next_mode = wr_mode ? lwr_mode_t'(reg_wdata) : mode;
      next_cfg = wr_cfg ? lwr_cfg_t'(reg_wdata) : cfg;
      // Status bits of the config register are never stored from a write.
      next_cfg.detector_output_status = det_s;
      next_cfg.between_samples_status = (next_seq == SEQ_WAIT);
      next_flags = flags;
      next_flags[FB_DATA_ACK] = 1'b0;
      next_flags[FB_CARRIER_ACK] = 1'b0;
      next_flags[FB_DATA_READY] = (flags[FB_DATA_READY] & ~clr_data) | set_data;
      next_flags[FB_MATCH_A] = (flags[FB_MATCH_A] & ~clr_data) | set_match_a;
      next_flags[FB_MATCH_B] = (flags[FB_MATCH_B] & ~clr_data) | set_match_b;
      next_flags[FB_CARRIER] = (flags[FB_CARRIER] & ~clr_car) | set_carrier;
      next_flags[FB_VIOLATION] = (flags[FB_VIOLATION] & ~clr_data & cfg.receiver_enable)
         | set_viol;
      if (wr_flag) begin
         next_flags[FB_IGNORE] = reg_wdata[FB_IGNORE];
      end
      // Read path; the received byte register has no write decode at all.
      next_mem_sel = reg_rd && reg_addr >= OFF_CODE_A0;
      next_reg_q = 8'h00;
      if (reg_rd) begin
         if (reg_addr == OFF_MODE) begin
            next_reg_q = mode;
         end else if (reg_addr == OFF_CFG) begin
            next_reg_q = cfg;
         end else if (reg_addr == OFF_FLAG) begin
            next_reg_q = flags;
         end else if (reg_addr == OFF_RXBYTE) begin
            next_reg_q = rx_byte;
         end
      end
   end

   lwr_code_mem #(
      .DEPTH(4),
      .WIDTH(8)
   ) u_code_mem (
      .clk(clk),
      .reset(reset),
      .wr_en(wr_code),
      .wr_addr(reg_addr[1:0]),
      .wr_data(reg_wdata),
      .rd_addr(reg_addr[1:0]),
      .rd_q(mem_q),
      .contents(codes)
   );

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lfo_div <= '0;
         mfo_div <= '0;
         seq <= SEQ_IDLE;
         per_cnt <= '0;
         win_cnt <= '0;
         car_cnt <= '0;
         frame <= FR_HUNT;
         shift <= '0;
         bit_cnt <= '0;
         rx_byte <= '0;
         mode <= lwr_mode_t'(RST_MODE);
         cfg <= lwr_cfg_t'(RST_CFG);
         flags <= RST_FLAG;
         reg_q <= '0;
         mem_sel <= 1'b0;
         irq_q <= 1'b0;
         rx_on_q <= 1'b0;
         sens_q <= 1'b0;
      end else begin
         lfo_div <= next_lfo_div;
         mfo_div <= next_mfo_div;
         seq <= next_seq;
         per_cnt <= next_per_cnt;
         win_cnt <= next_win_cnt;
         car_cnt <= next_car_cnt;
         frame <= next_frame;
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         rx_byte <= next_rx_byte;
         mode <= next_mode;
         cfg <= next_cfg;
         flags <= next_flags;
         reg_q <= next_reg_q;
         mem_sel <= next_mem_sel;
         irq_q <= cfg.receiver_irq_enable & (flags[FB_CARRIER] | flags[FB_DATA_READY]);
         rx_on_q <= (next_seq == SEQ_WIN);
         sens_q <= cfg.sensitivity_sel;
      end
   end

   // Both read sources are registers; only the final select follows them.
   assign reg_rdata = mem_sel ? mem_q : reg_q;
   assign lf_wake_irq = irq_q;
   assign receiver_active = rx_on_q;
   assign high_sensitivity = sens_q;

   property p_carrier_set;
      @(posedge clk) disable iff (reset)
      (seq == SEQ_WIN && mfo_tick && carrier_mode && det_eff && car_cnt == car_ticks - 5'h1)
         |=> flags[FB_CARRIER];
   endproperty
   a_carrier_set: assert property (p_carrier_set) else $error("carrier flag not set");

   property p_carrier_ack;
      @(posedge clk) disable iff (reset)
      (clr_car && !set_carrier) |=> !flags[FB_CARRIER];
   endproperty
   a_carrier_ack: assert property (p_carrier_ack) else $error("carrier ack failed");

   property p_data_ack;
      @(posedge clk) disable iff (reset)
      (clr_data && !set_data && !set_match_a && !set_match_b)
         |=> !flags[FB_DATA_READY] && !flags[FB_MATCH_A] && !flags[FB_MATCH_B];
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data ack failed");

   property p_irq;
      @(posedge clk) disable iff (reset)
      (cfg.receiver_irq_enable && flags[FB_CARRIER]) |=> lf_wake_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("wake interrupt missing");

   property p_enable_off;
      @(posedge clk) disable iff (reset)
      !cfg.receiver_enable |=> !receiver_active ##1 !receiver_active;
   endproperty
   a_enable_off: assert property (p_enable_off) else $error("receiver active while off");

   property p_rx_readonly;
      @(posedge clk) disable iff (reset)
      (reg_wr && reg_addr == OFF_RXBYTE && !set_data) |=> $stable(rx_byte);
   endproperty
   a_rx_readonly: assert property (p_rx_readonly) else $error("received byte written");

   property p_ack_reads_zero;
      @(posedge clk) disable iff (reset)
      (reg_rd && reg_addr == OFF_FLAG) |=> !reg_rdata[FB_DATA_ACK] && !reg_rdata[FB_CARRIER_ACK];
   endproperty
   a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read as 1");

   property p_window_end;
      @(posedge clk) disable iff (reset)
      (seq == SEQ_WIN && mfo_tick && win_cnt == win_ticks - 9'h1 && cfg.receiver_enable)
         |=> seq == SEQ_WAIT && !receiver_active;
   endproperty
   a_window_end: assert property (p_window_end) else $error("window length wrong");

   property p_no_match_in_carrier;
      @(posedge clk) disable iff (reset)
      carrier_mode |-> !set_match_a && !set_match_b && !set_data;
   endproperty
   a_no_match_in_carrier: assert property (p_no_match_in_carrier) else $error("code used");

endmodule : lwr_wakeup_ctrl

// >>> pkg/lwr_pkg.sv
// Purpose: Shared constants and types for the low-frequency wake-up receiver control block.
// Assumes: 100 MHz system clock; registers are eight bits wide on a plain strobe port.
// Notes: The register offsets are local indices on the plain register port.
package lwr_pkg;

   // Register offsets.
   localparam logic [2:0] OFF_MODE = 3'h0;
   localparam logic [2:0] OFF_CFG = 3'h1;
   localparam logic [2:0] OFF_FLAG = 3'h2;
   localparam logic [2:0] OFF_RXBYTE = 3'h3;
   localparam logic [2:0] OFF_CODE_A0 = 3'h4;
   localparam logic [2:0] OFF_CODE_B1 = 3'h7;

   // Reset values.
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_FLAG = 8'h00;

   // Bit positions in the flag/status register.
   localparam int FB_DATA_READY = 7;
   localparam int FB_DATA_ACK = 6;
   localparam int FB_CARRIER = 5;
   localparam int FB_CARRIER_ACK = 4;
   localparam int FB_MATCH_B = 3;
   localparam int FB_MATCH_A = 2;
   localparam int FB_VIOLATION = 1;
   localparam int FB_IGNORE = 0;

   // Receive mode encodings.
   localparam logic [1:0] MODE_CARRIER = 2'h1;
   localparam logic [1:0] MODE_MANCHESTER = 2'h2;

   // Timing: the low and medium frequency time bases.
   localparam int CLK_PERIOD_NS = 10;
   localparam int LFO_PERIOD_NS = 1000000;
   localparam int MFO_PERIOD_NS = 8000;
   localparam int LFO_CYCLES = LFO_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MFO_CYCLES = MFO_PERIOD_NS / CLK_PERIOD_NS;
   localparam int WIN_SHORT_US = 200;
   localparam int WIN_LONG_US = 2120;
   localparam int CARRIER_SHORT_US = 88;
   localparam int CARRIER_LONG_US = 176;
   localparam logic [8:0] WIN_SHORT_TICKS = 9'((WIN_SHORT_US * 1000 + MFO_PERIOD_NS - 1) / MFO_PERIOD_NS);
   localparam logic [8:0] WIN_LONG_TICKS = 9'((WIN_LONG_US * 1000 + MFO_PERIOD_NS - 1) / MFO_PERIOD_NS);
   localparam logic [4:0] CARRIER_SHORT_TICKS = 5'((CARRIER_SHORT_US * 1000 + MFO_PERIOD_NS - 1) / MFO_PERIOD_NS);
   localparam logic [4:0] CARRIER_LONG_TICKS = 5'((CARRIER_LONG_US * 1000 + MFO_PERIOD_NS - 1) / MFO_PERIOD_NS);

   // Synchronisation character that opens a Manchester frame (arbitrary value).
   localparam logic [7:0] SYNC_CHAR = 8'h96;

   typedef struct packed {
      logic [1:0] receive_mode_sel;
      logic min_carrier_length_sel;
      logic sample_window_length;
      logic [3:0] sample_interval_sel;
   } lwr_mode_t;

   typedef struct packed {
      logic detector_output_status;
      logic receiver_irq_enable;
      logic between_samples_status;
      logic off_time_sel;
      logic receiver_enable;
      logic wake_code_width_sel;
      logic sensitivity_sel;
      logic gain_readback_sel;
   } lwr_cfg_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_WAIT = 2'b01,
      SEQ_WIN = 2'b11
   } lwr_seq_t;

   typedef enum logic [1:0] {
      FR_HUNT = 2'b00,
      FR_ID = 2'b01,
      FR_DATA = 2'b11
   } lwr_frame_t;

endpackage : lwr_pkg

// >>> verif/lwr_lf_sender.sv
// Purpose: Far-side model: LF trigger transmitter as seen through the analogue detector.
// Assumes: Carrier only reaches the detector while the receiver is sampling.
// Notes: One 24-bit frame is sent, first bit first, once frame_send is up and a window opens.
// Notes: Outside the frame the decoded bit line toggles, so it is never trusted idle.
`timescale 1ns/100ps
module lwr_lf_sender (
   // Clock.
   input wire logic clk,
   // Control from the bench and the receiver.
   input wire logic receiver_active,
   input wire logic carrier_on,
   input wire logic slow,
   input wire logic frame_send,
   input wire logic [23:0] lf_frame,
   // Detector and decoder outputs.
   output logic detector_out,
   output logic dec_bit,
   output logic dec_bit_strobe,
   output logic dec_violation
);
   int lag, nb, ph;

   initial begin
      lag = 0;
      nb = 0;
      ph = 0;
      detector_out = 1'b0;
      dec_bit = 1'b0;
      dec_bit_strobe = 1'b0;
      dec_violation = 1'b0;
   end

   // A slow detector settles late inside the window, leaving less margin for the count.
   always @(posedge clk) begin
      lag <= (receiver_active && carrier_on) ? lag + 1 : 0;
      detector_out <= carrier_on && receiver_active && (lag >= (slow ? 20 : 1));
      // Each bit is held for eight clocks and strobed in the middle, so it is settled
      // well before and after the strobe edge even through the receiver's synchronisers.
      if (frame_send && receiver_active && nb < 24) begin
         ph <= (ph == 7) ? 0 : ph + 1;
         if (ph == 0) begin
            dec_bit <= lf_frame[23 - nb];
         end
         if (ph == 3) begin
            dec_bit_strobe <= 1'b1;
         end
         if (ph == 6) begin
            dec_bit_strobe <= 1'b0;
         end
         if (ph == 7) begin
            nb <= nb + 1;
         end
      end else begin
         dec_bit <= ~dec_bit;
      end
   end
endmodule : lwr_lf_sender

// >>> verif/lwr_wakeup_ctrl_bench.sv
// Purpose: Self-checking bench for the wake-up receiver control block.
// Assumes: Dividers shortened to 20 and 4 cycles; interval code 0 gives one 200 ns tick.
// Notes: Registers are mirrored in a model array masked by their writable bits.
`timescale 1ns/100ps
module lwr_wakeup_ctrl_bench;
   import lwr_pkg::*;
   localparam int MDIV = 4;
   logic clk, reset, reg_wr, reg_rd, carrier_on, slow;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic detector_out, dec_bit, dec_bit_strobe, dec_violation;
   logic receiver_active, high_sensitivity, lf_wake_irq;
   logic frame_send;
   logic [23:0] lf_frame;
   logic [7:0] id, dat;
   int miscompares, n_tests, cnt, ws;
   logic [7:0] model [8];
   bit got;

   lwr_wakeup_ctrl #(.LFO_DIV(20), .MFO_DIV(MDIV)) uut (.clk(clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .detector_out(detector_out), .dec_bit(dec_bit),
      .dec_bit_strobe(dec_bit_strobe), .dec_violation(dec_violation),
      .receiver_active(receiver_active), .high_sensitivity(high_sensitivity),
      .lf_wake_irq(lf_wake_irq));
   lwr_lf_sender far (.clk(clk), .receiver_active(receiver_active), .carrier_on(carrier_on),
      .slow(slow), .frame_send(frame_send), .lf_frame(lf_frame),
      .detector_out(detector_out), .dec_bit(dec_bit),
      .dec_bit_strobe(dec_bit_strobe), .dec_violation(dec_violation));

   function automatic logic [7:0] wmask(input int a);
      return (a == 1) ? 8'h5f : (a == 2) ? 8'h01 : (a == 3) ? 8'h00 : 8'hff;
   endfunction : wmask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_tests++;
      if (s !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, s);
         miscompares++;
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      model[a] = d & wmask(a);
   endtask : wr

   task automatic rd(input logic [2:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("reg%0d", a), model[a], reg_rdata);
   endtask : rd

   task automatic wait_lvl(input logic lvl, input int lim, output bit ok);
      ok = 0;
      repeat (lim) begin
         @(posedge clk);
         if (lf_wake_irq === lvl && lvl !== 1'bz) begin
            ok = 1;
            break;
         end
      end
   endtask : wait_lvl

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end

   initial begin
      reset = 1'b1;
      {reg_wr, reg_rd, carrier_on, slow, frame_send} = 5'h0;
      lf_frame = '0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      miscompares = 0;
      n_tests = 0;
      foreach (model[i]) model[i] = 8'h00;
      void'($urandom(15));
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      for (int a = 0; a < 8; a++) rd(3'(a));
      for (int a = 0; a < 8; a++) wr(3'(a), 8'($urandom()));
      model[1] = 8'h00;
      wr(3'h1, 8'h00);
      for (int a = 0; a < 8; a++) rd(3'(a));
      wr(3'h2, 8'hff);
      rd(3'h2);
      // Carrier mode set up fully before the enable goes on.
      wr(3'h0, 8'h40);
      wr(3'h2, 8'h50);
      carrier_on <= 1'b1;
      slow <= 1'b1;
      wr(3'h1, 8'h5a);
      // The sensitivity output follows the stored bit one clock later.
      @(posedge clk);
      @(negedge clk);
      chk("high_sensitivity", 8'h01, {7'h0, high_sensitivity});
      wait_lvl(1'b1, 3000, got);
      chk("irq_raised", 8'h01, {7'h0, got});
      model[2] = 8'h20;
      rd(3'h2);
      wr(3'h1, 8'h52);
      wr(3'h2, 8'h00);
      model[2] = 8'h20;
      rd(3'h2);
      wr(3'h2, 8'h10);
      rd(3'h2);
      repeat (2) @(posedge clk);
      chk("irq_cleared", 8'h00, {7'h0, lf_wake_irq});
      slow <= 1'b0;
      wr(3'h2, 8'h01);
      for (ws = 0; ws < 2; ws++) begin
         wr(3'h1, 8'h02);
         wr(3'h0, {2'b01, 1'b0, 1'(ws), 4'h0});
         wr(3'h1, 8'h1a);
         cnt = 0;
         repeat (3000) begin
            @(posedge clk);
            if (receiver_active === 1'b1) break;
         end
         while (receiver_active === 1'b1 && cnt < 1200) begin
            @(posedge clk);
            cnt++;
         end
         got = (cnt >= (ws ? 265 : 25) * MDIV - 4) && (cnt <= (ws ? 265 : 25) * MDIV + 1);
         chk("window_len", 8'h01, {7'h0, got});
         rd(3'h2);
      end
      wr(3'h2, 8'h00);
      repeat (3000) begin
         @(posedge clk);
         if (receiver_active === 1'b1) break;
      end
      repeat (1200) begin
         @(posedge clk);
         if (receiver_active !== 1'b1) break;
      end
      model[2] = 8'h20;
      rd(3'h2);
      chk("irq_masked", 8'h00, {7'h0, lf_wake_irq});
      // Manchester frame: codes and mode are loaded while the receiver is off.
      wr(3'h1, 8'h00);
      carrier_on <= 1'b0;
      id = 8'($urandom());
      dat = 8'($urandom());
      wr(3'h4, id);
      wr(3'h6, ~id);
      wr(3'h0, 8'h90);
      wr(3'h2, 8'h50);
      lf_frame <= {SYNC_CHAR, id, dat};
      frame_send <= 1'b1;
      wr(3'h1, 8'h48);
      wait_lvl(1'b1, 3000, got);
      chk("data_irq", 8'h01, {7'h0, got});
      model[2] = 8'h84;
      rd(3'h2);
      model[3] = dat;
      rd(3'h3);
      wr(3'h2, 8'h40);
      rd(3'h2);
      wrap_up();
   end
endmodule : lwr_wakeup_ctrl_bench
